// *** sim/dca_adapter_props.sv ***
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module dca_adapter_props
  import dca_pkg::*;
(
  input wire         clk,
  input wire         reset,
  input wire         start_valid,
  input wire  [7:0]  start_addr,
  input logic        start_ready,
  input wire         reconnect_valid,
  input logic        reconnect_ready,
  input logic        busy,
  input logic        steal_req,
  input logic [23:0] steal_addr,
  input wire         steal_ack,
  input logic        end_valid,
  input dca_end_t    end_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // One program owns the channel; others wait for idle
  property p_one; busy |-> !start_ready && !reconnect_ready; endproperty
  a_one: assert property (p_one) else $error("ready while busy");
  property p_recon; reconnect_valid && !busy |-> !start_ready ##1 (busy ^ end_valid); endproperty
  a_recon: assert property (p_recon) else $error("start beat reconnect");
  property p_hold; steal_req && !steal_ack |=> steal_req && $stable(steal_addr); endproperty
  a_hold: assert property (p_hold) else $error("steal request dropped");
  property p_gap; steal_ack |=> !steal_req; endproperty
  a_gap: assert property (p_gap) else $error("no idle between steals");
  property p_steal; steal_req |-> busy; endproperty
  a_steal: assert property (p_steal) else $error("steal while idle");
  property p_pulse; end_valid |=> !end_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("end not a pulse");
  property p_rej; start_valid && start_ready && start_addr == 8'h99 |=> end_valid && end_code == END_REJECT; endproperty
  a_rej: assert property (p_rej) else $error("unknown address taken");
  property p_rst; $fell(reset) |-> !busy && !steal_req && !end_valid; endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
endmodule : dca_adapter_props
bind dca_adapter dca_adapter_props props_u (.*);

// *** sim/dca_adapter_tb.sv ***
`timescale 1ns/1ps
// ****************
// Adapter bench
// ****************
module dca_adapter_tb;
  import dca_pkg::*;
  logic clk = 1'b0, reset = 1'b1, cfg_valid = 1'b0, ckd_code_loaded = 1'b0, start_valid = 1'b0;
  logic reconnect_valid = 1'b0, dev_stat_de = 1'b1, dev_in_valid = 1'b1, dev_stat_valid = 1'b1, dev_stat_ce = 1'b1;
  logic [1:0] cfg_string = 2'h0;
  dca_dev_t cfg_type = DEV_NONE;
  logic [7:0] cfg_base = 8'h0, start_addr = 8'h0, reconnect_addr = 8'h0;
  logic [3:0] cfg_count = 4'h0;
  logic [23:0] start_ccw = 24'h0, steal_addr;
  logic [6:0] ucode_addr = 7'h0;
  logic start_ready, reconnect_ready, dev_in_ready, dev_out_valid, dev_out_ready, dev_stat_ready, steal_req, steal_we;
  logic steal_ack, busy, end_valid;
  logic [31:0] dev_in_data, dev_out_data, steal_wdata, steal_rdata, ucode_data;
  logic [4:0] end_subch;
  dca_end_t end_code;
  int miscompares = 0, comparisons = 0, cycles = 0, words = 0;
  dca_adapter dut_u (.*);
  dca_far_model part_u (.*);
  always #20 clk = ~clk;
  // Cut a hang short well past the longest program
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end
  // Words leave for the drive in storage order; negedge sees the settled handshake
  always @(negedge clk) begin
    if (dev_out_valid && dev_out_ready) begin
      chk(dev_out_data === 32'(words), "write word");
      words++;
    end
  end
  task summarize;
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic cfg(input logic [1:0] s, input dca_dev_t t, input logic [7:0] b, input logic [3:0] n);
    @(posedge clk);
    cfg_valid  <= 1'b1;
    cfg_string <= s;
    cfg_type   <= t;
    cfg_base   <= b;
    cfg_count  <= n;
    @(posedge clk);
    cfg_valid <= 1'b0;
  endtask : cfg
  // Issue one start or reconnect and judge the end report
  task automatic run(input bit rc, input logic [7:0] a, input logic [23:0] c, input dca_end_t ec, input logic [4:0] es);
    int n = 0;
    @(posedge clk);
    {reconnect_valid, start_valid, reconnect_addr, start_addr, start_ccw} <= {rc, !rc, a, a, c};
    @(posedge clk);
    {reconnect_valid, start_valid} <= 2'h0;
    @(negedge clk);
    while (end_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 5000 && end_code === ec && end_subch === es, "end report");
    @(posedge clk);
  endtask : run
  task t_read;
    part_u.mem[32'h100] = {8'h02, 24'h001000};
    part_u.mem[32'h104] = 32'h200;
    run(0, 8'h42, 24'h100, END_DONE, 5'h02);
    chk(part_u.mem.exists(32'h11fc) && !part_u.mem.exists(32'h1200), "block length");
    chk(part_u.mem[32'h1000] === 32'h0, "first word");
    @(posedge clk);
    ucode_addr <= 7'h10;
    @(posedge clk);
    @(negedge clk);
    chk(ucode_data === {8'ha5, UCODE_AREA_BASE}, "paged code");
  endtask : t_read
  // Write the block read above back out to the drive
  task t_write;
    part_u.mem[32'h300] = {8'h01, 24'h001000};
    part_u.mem[32'h304] = 32'h200;
    run(0, 8'h42, 24'h300, END_DONE, 5'h02);
    chk(words == 128, "write length");
  endtask : t_write
  // Data-chained input on a fixed-block drive runs through the prefetched word
  task t_chain;
    part_u.mem[32'h400] = {8'h02, 24'h004000};
    part_u.mem[32'h404] = 32'h8000_0200;
    part_u.mem[32'h408] = {8'h02, 24'h005000};
    part_u.mem[32'h40c] = 32'h200;
    run(0, 8'h61, 24'h400, END_DONE, 5'h11);
    chk(part_u.mem[32'h4000] === 32'h80 && part_u.mem[32'h5000] === 32'h100, "chained data");
    chk(part_u.mem.exists(32'h51fc) && !part_u.mem.exists(32'h5200), "chained length");
  endtask : t_chain
  task t_disc;
    part_u.mem[32'h180] = {8'h02, 24'h002000};
    part_u.mem[32'h184] = 32'h4;
    run(0, 8'h70, 24'h180, END_ERROR, 5'h18);
    part_u.mem[32'h200] = 32'h0;
    part_u.mem[32'h204] = 32'h0;
    part_u.mem[32'h280] = 32'h0;
    part_u.mem[32'h284] = 32'h4000_0000;
    part_u.mem[32'h288] = {8'h02, 24'h003000};
    part_u.mem[32'h28c] = 32'h4;
    dev_stat_de <= 1'b0;
    run(0, 8'h53, 24'h280, END_DISC, 5'h0b);
    chk(part_u.mem[SUBCH_AREA_BASE + 24'h58] === 32'h288, "saved pointer");
    chk(part_u.mem[SUBCH_AREA_BASE + 24'h5c] === 32'h4000_0000, "saved chain");
    dev_stat_de <= 1'b1;
    // Resumed command has a bad block length, so only a real resume ends in error
    run(1, 8'h53, 24'h0, END_ERROR, 5'h0b);
  endtask : t_disc
  task t_cfg;
    cfg(1, DEV_FBA_B, 8'h20, 4'h8);
    run(0, 8'h27, 24'h200, END_DONE, 5'h0f);
    run(0, 8'h52, 24'h200, END_REJECT, 5'h00);
    cfg(2, DEV_CKD, 8'h78, 4'h8);
    run(0, 8'h7f, 24'h200, END_REJECT, 5'h00);
    ckd_code_loaded <= 1'b1;
    run(0, 8'h7f, 24'h200, END_DONE, 5'h17);
    cfg(3, DEV_CKD, 8'h7c, 4'h8);
    run(0, 8'h80, 24'h200, END_REJECT, 5'h00);
    run(0, 8'h99, 24'h200, END_REJECT, 5'h00);
  endtask : t_cfg
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_read();
    t_write();
    t_chain();
    t_disc();
    t_cfg();
    summarize();
  end
endmodule : dca_adapter_tb

// *** sim/dca_far_model.sv ***
`timescale 1ns/1ps
// ****************
// Storage bus and drive string model
// ****************
module dca_far_model (
  input  wire         clk,
  input  wire         reset,
  input  wire         steal_req,
  input  wire         steal_we,
  input  wire  [23:0] steal_addr,
  input  wire  [31:0] steal_wdata,
  output logic        steal_ack,
  output logic [31:0] steal_rdata,
  output logic [31:0] dev_in_data,
  input  wire         dev_in_ready,
  output logic        dev_out_ready
);
  logic [31:0] mem [int];
  logic [1:0]  cnt;
  logic        slow;
  // Answer latency alternates so prompt and slow bus cycles both occur
  always @(posedge clk) begin
    steal_ack <= 1'b0;
    steal_rdata <= ~steal_rdata; // Released bus flips the old word every cycle
    dev_out_ready <= !dev_out_ready && !reset; // Drive stalls every other cycle
    if (reset) begin
      cnt <= 2'h0;
      slow <= 1'b0;
      steal_rdata <= 32'h0;
      dev_in_data <= 32'h0;
    end else begin
      if (dev_in_ready) dev_in_data <= dev_in_data + 32'h1;
      if (steal_req && !steal_ack) begin
        cnt <= cnt + 2'h1;
        if (cnt == (slow ? 2'h3 : 2'h1)) begin
          cnt <= 2'h0;
          slow <= !slow;
          steal_ack <= 1'b1;
          if (steal_we) mem[steal_addr] = steal_wdata;
          else steal_rdata <= mem.exists(steal_addr) ? mem[steal_addr] : {8'ha5, steal_addr};
        end
      end
    end
  end
endmodule : dca_far_model

// *** src/dca_adapter.sv ***
`timescale 1ns/1ps
module dca_adapter
  import dca_pkg::*;
(
  input  wire         clk,
  input  wire         reset,
  input  wire         cfg_valid,
  input  wire  [1:0]  cfg_string,
  input  dca_dev_t    cfg_type,
  input  wire  [7:0]  cfg_base,
  input  wire  [3:0]  cfg_count,
  input  wire         ckd_code_loaded,
  input  wire         start_valid,
  input  wire  [7:0]  start_addr,
  input  wire  [23:0] start_ccw,
  output logic        start_ready,
  input  wire         reconnect_valid,
  input  wire  [7:0]  reconnect_addr,
  output logic        reconnect_ready,
  input  wire         dev_in_valid,
  input  wire  [31:0] dev_in_data,
  output logic        dev_in_ready,
  output logic        dev_out_valid,
  output logic [31:0] dev_out_data,
  input  wire         dev_out_ready,
  input  wire         dev_stat_valid,
  input  wire         dev_stat_ce,
  input  wire         dev_stat_de,
  output logic        dev_stat_ready,
  output logic        steal_req,
  output logic        steal_we,
  output logic [23:0] steal_addr,
  output logic [31:0] steal_wdata,
  input  wire         steal_ack,
  input  wire  [31:0] steal_rdata,
  input  wire  [6:0]  ucode_addr,
  output logic [31:0] ucode_data,
  output logic        busy,
  output logic        end_valid,
  output logic [4:0]  end_subch,
  output dca_end_t    end_code
);

  // ****************************************************************
  // Configuration of the attached strings
  // ****************************************************************
  dca_dev_t   str_type       [NUM_STRINGS];
  logic [7:0] str_base       [NUM_STRINGS];
  logic [3:0] str_count      [NUM_STRINGS];
  dca_dev_t   next_str_type  [NUM_STRINGS];
  logic [7:0] next_str_base  [NUM_STRINGS];
  logic [3:0] next_str_count [NUM_STRINGS];

  // Any string may take any type, so types mix freely on one adapter
  always_comb begin
    next_str_type  = str_type;
    next_str_base  = str_base;
    next_str_count = str_count;
    if (cfg_valid) begin
      next_str_type[cfg_string]  = cfg_type;
      next_str_base[cfg_string]  = cfg_base;
      next_str_count[cfg_string] = cfg_count;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_STRINGS; i++) begin
        str_type[i]  <= DEV_FBA_A;
        str_base[i]  <= STD_BASE[i];
        str_count[i] <= STD_COUNT;
      end
    end else begin
      str_type  <= next_str_type;
      str_base  <= next_str_base;
      str_count <= next_str_count;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic [NUM_STRINGS-1:0] str_hit;
  logic [4:0]             str_subch [NUM_STRINGS];
  logic [7:0]             dec_addr;
  logic                   dec_ok;
  logic [4:0]             dec_subch;
  dca_dev_t               dec_type;

  // Reconnection is looked at first; both share one decoder
  assign dec_addr = reconnect_valid ? reconnect_addr : start_addr;

  generate
    for (genvar g = 0; g < NUM_STRINGS; g++) begin : g_dec
      dca_string_decode #(.STRING_ID(2'(g))) u_dec (
        .str_type  (str_type[g]),
        .str_base  (str_base[g]),
        .str_count (str_count[g]),
        .addr      (dec_addr),
        .hit       (str_hit[g]),
        .subch     (str_subch[g])
      );
    end
  endgenerate

  // Lowest matching string wins; overlapping ranges are a setup fault
  always_comb begin
    dec_ok    = 1'b0;
    dec_subch = 5'h00;
    dec_type  = DEV_NONE;
    for (int i = NUM_STRINGS - 1; i >= 0; i--) begin
      if (str_hit[i] && ((str_type[i] != DEV_CKD) || ckd_code_loaded)) begin
        dec_ok    = 1'b1;
        dec_subch = str_subch[i];
        dec_type  = str_type[i];
      end
    end
  end

  // ****************************************************************
  // Channel engine
  // ****************************************************************
  dca_state_t  state, next_state;
  logic [3:0]  step, next_step;
  logic [4:0]  subch, next_subch;
  dca_dev_t    dtype, next_dtype;
  logic        act, next_act;
  logic        pf, next_pf;
  logic        pg_valid, next_pg_valid;
  logic        pg_id, next_pg_id;
  logic [23:0] w_ccw  [NUM_WORKING];
  logic [23:0] w_dadr [NUM_WORKING];
  logic [7:0]  w_cmd  [NUM_WORKING];
  logic [13:0] w_cnt  [NUM_WORKING];
  logic        w_cd   [NUM_WORKING];
  logic        w_cc   [NUM_WORKING];
  logic [23:0] next_w_ccw  [NUM_WORKING];
  logic [23:0] next_w_dadr [NUM_WORKING];
  logic [7:0]  next_w_cmd  [NUM_WORKING];
  logic [13:0] next_w_cnt  [NUM_WORKING];
  logic        next_w_cd   [NUM_WORKING];
  logic        next_w_cc   [NUM_WORKING];
  logic [31:0] store [STORE_WORDS];
  logic [31:0] next_store [STORE_WORDS];
  logic [1:0]  bv, next_bv;
  logic        fill, next_fill;
  logic        drain, next_drain;
  logic [13:0] in_left, next_in_left;
  logic        next_steal_req, next_steal_we;
  logic [23:0] next_steal_addr;
  logic [31:0] next_steal_wdata;
  logic        next_end_valid;
  logic [4:0]  next_end_subch;
  dca_end_t    next_end_code;
  logic        is_read, is_fba, pg_want;
  logic [23:0] step_off, sub_addr;

  assign is_read  = (w_cmd[act][1:0] == CMD_READ);
  assign is_fba   = (dtype == DEV_FBA_A) || (dtype == DEV_FBA_B);
  assign pg_want  = (dtype == DEV_CKD);
  assign step_off = {18'h0, step, 2'h0};
  assign sub_addr = SUBCH_AREA_BASE + {16'h0, subch, 3'h0} + step_off;

  // Handshakes; requests wait while the channel is busy, and a reconnection goes ahead of a start
  assign reconnect_ready = (state == S_IDLE);
  assign start_ready     = (state == S_IDLE) && !reconnect_valid;
  assign dev_in_ready    = (state == S_XFER) && is_read && !bv[fill] && (in_left != 14'h0);
  assign dev_out_valid   = (state == S_XFER) && !is_read && bv[drain];
  assign dev_out_data    = store[{6'h0, drain}];
  assign dev_stat_ready  = (state == S_STAT);
  assign busy            = (state != S_IDLE);

  always_comb begin
    next_state = state;  next_step = step;  next_subch = subch;  next_dtype = dtype;
    next_act = act;  next_pf = pf;  next_pg_valid = pg_valid;  next_pg_id = pg_id;
    next_w_ccw = w_ccw;  next_w_dadr = w_dadr;  next_w_cmd = w_cmd;
    next_w_cnt = w_cnt;  next_w_cd = w_cd;  next_w_cc = w_cc;
    next_store = store;  next_bv = bv;  next_fill = fill;  next_drain = drain;
    next_in_left = in_left;
    next_steal_req = steal_req && !steal_ack;
    next_steal_we = steal_we;  next_steal_addr = steal_addr;  next_steal_wdata = steal_wdata;
    next_end_valid = 1'b0;  next_end_subch = end_subch;  next_end_code = end_code;
    case (state)
      S_IDLE: begin
        next_step = 4'h0;
        if (reconnect_valid || start_valid) begin
          if (dec_ok) begin
            next_subch = dec_subch;
            next_dtype = dec_type;
            next_act   = 1'b0;
            next_pf    = 1'b0;
            if (reconnect_valid) begin
              next_state = S_LOAD;
            end else begin
              next_w_ccw[0] = start_ccw;
              next_state    = S_PAGE;
            end
          end else begin
            next_end_valid = 1'b1;
            next_end_subch = 5'h00;
            next_end_code  = END_REJECT;
          end
        end
      end
      // Restore the saved command pointer of a disconnected program
      S_LOAD: begin
        if (!steal_req) begin
          next_steal_req = 1'b1;  next_steal_we = 1'b0;  next_steal_addr = sub_addr;
        end else if (steal_ack) begin
          next_step = step + 4'h1;
          if (step == 4'h0) begin
            next_w_ccw[act] = steal_rdata[23:0];
          end else begin
            next_step = 4'h0;
            next_w_cc[act] = steal_rdata[CCW_CHAIN_CMD_BIT];
            if (steal_rdata[CCW_CHAIN_CMD_BIT]) begin
              next_state = S_PAGE;
            end else begin
              next_state = S_IDLE;
              next_end_valid = 1'b1;  next_end_subch = subch;  next_end_code = END_DONE;
            end
          end
        end
      end
      // One page slot; a change between CKD and fixed-block types costs one page load
      S_PAGE: begin
        if (pg_valid && (pg_id == pg_want)) begin
          next_state = S_FETCH;
        end else if (!steal_req) begin
          next_steal_req  = 1'b1;  next_steal_we = 1'b0;
          next_steal_addr = UCODE_AREA_BASE + (pg_want ? UCODE_PAGE_SIZE : 24'h0) + step_off;
          next_pg_valid   = 1'b0;
        end else if (steal_ack) begin
          next_store[PAGE_SLOT + {3'h0, step}] = steal_rdata;
          next_step = step + 4'h1;
          if (step == PAGE_LAST_STEP) begin
            next_step = 4'h0;  next_pg_valid = 1'b1;  next_pg_id = pg_want;
            next_state = S_FETCH;
          end
        end
      end
      S_FETCH: begin
        if (!steal_req) begin
          next_steal_req = 1'b1;  next_steal_we = 1'b0;  next_steal_addr = w_ccw[act] + step_off;
        end else if (steal_ack) begin
          next_step = 4'h1;
          if (step == 4'h0) begin
            next_w_cmd[act]  = steal_rdata[31:24];
            next_w_dadr[act] = steal_rdata[23:0];
          end else begin
            next_step       = 4'h0;
            next_w_cd[act]  = steal_rdata[CCW_CHAIN_DATA_BIT];
            next_w_cc[act]  = steal_rdata[CCW_CHAIN_CMD_BIT];
            next_w_cnt[act] = steal_rdata[15:2];
            next_w_ccw[act] = w_ccw[act] + CCW_BYTES;
            next_in_left    = steal_rdata[15:2];
            next_bv = 2'h0;  next_fill = 1'b0;  next_drain = 1'b0;
            if ((w_cmd[act][1:0] != CMD_READ) && (w_cmd[act][1:0] != CMD_WRITE)) begin
              next_state = S_STAT;
            end else if (is_fba && ((steal_rdata[8:0] & BLOCK_MASK) != 9'h0)) begin
              next_state = S_IDLE;
              next_end_valid = 1'b1;  next_end_subch = subch;  next_end_code = END_ERROR;
            end else if (steal_rdata[CCW_CHAIN_DATA_BIT] && is_read && is_fba) begin
              next_state = S_PREF;
            end else begin
              next_state = S_XFER;
            end
          end
        end
      end
      // Next command word goes into the idle working word
      S_PREF: begin
        if (!steal_req) begin
          next_steal_req = 1'b1;  next_steal_we = 1'b0;  next_steal_addr = w_ccw[act] + step_off;
        end else if (steal_ack) begin
          next_step = 4'h1;
          if (step == 4'h0) begin
            next_w_cmd[!act]  = steal_rdata[31:24];
            next_w_dadr[!act] = steal_rdata[23:0];
          end else begin
            next_step        = 4'h0;
            next_w_cd[!act]  = steal_rdata[CCW_CHAIN_DATA_BIT];
            next_w_cc[!act]  = steal_rdata[CCW_CHAIN_CMD_BIT];
            next_w_cnt[!act] = steal_rdata[15:2];
            next_w_ccw[!act] = w_ccw[act] + CCW_BYTES;
            next_pf    = 1'b1;
            next_state = S_XFER;
          end
        end
      end
      // Two one-word buffers alternate so device and bus overlap
      S_XFER: begin
        if (is_read) begin
          if (dev_in_valid && dev_in_ready) begin
            next_store[{6'h0, fill}] = dev_in_data;
            next_bv[fill] = 1'b1;  next_fill = !fill;  next_in_left = in_left - 14'h1;
          end
          if (!steal_req && bv[drain]) begin
            next_steal_req   = 1'b1;  next_steal_we = 1'b1;
            next_steal_addr  = w_dadr[act];
            next_steal_wdata = store[{6'h0, drain}];
          end else if (steal_req && steal_ack) begin
            next_bv[drain] = 1'b0;  next_drain = !drain;
            next_w_cnt[act]  = w_cnt[act] - 14'h1;
            next_w_dadr[act] = w_dadr[act] + 24'h4;
          end
        end else begin
          if (!steal_req && !bv[fill] && (in_left != 14'h0)) begin
            next_steal_req = 1'b1;  next_steal_we = 1'b0;  next_steal_addr = w_dadr[act];
          end else if (steal_req && steal_ack) begin
            next_store[{6'h0, fill}] = steal_rdata;
            next_bv[fill] = 1'b1;  next_fill = !fill;  next_in_left = in_left - 14'h1;
            next_w_dadr[act] = w_dadr[act] + 24'h4;
          end
          if (dev_out_valid && dev_out_ready) begin
            next_bv[drain] = 1'b0;  next_drain = !drain;
            next_w_cnt[act] = w_cnt[act] - 14'h1;
          end
        end
        if ((w_cnt[act] == 14'h0) && !steal_req) begin
          if (!w_cd[act]) begin
            next_state = S_STAT;
          end else if (pf) begin
            next_act = !act;
            next_pf  = 1'b0;
            next_in_left = w_cnt[!act];
            if (w_cd[!act]) begin
              next_state = S_PREF;
            end
          end else begin
            next_state = S_FETCH;
          end
        end
      end
      S_STAT: begin
        if (dev_stat_valid) begin
          if (dev_stat_de) begin
            if (w_cc[act]) begin
              next_state = S_FETCH;
            end else begin
              next_state = S_IDLE;
              next_end_valid = 1'b1;  next_end_subch = subch;  next_end_code = END_DONE;
            end
          end else if (dev_stat_ce) begin
            next_state = S_SAVE;
          end
        end
      end
      // Park the program in processor storage and free the channel
      S_SAVE: begin
        if (!steal_req) begin
          next_steal_req   = 1'b1;  next_steal_we = 1'b1;  next_steal_addr = sub_addr;
          next_steal_wdata = (step == 4'h0) ? {8'h0, w_ccw[act]}
                             : {1'b0, w_cc[act], 30'h0};
        end else if (steal_ack) begin
          next_step = 4'h1;
          if (step != 4'h0) begin
            next_step  = 4'h0;
            next_state = S_IDLE;
            next_end_valid = 1'b1;  next_end_subch = subch;  next_end_code = END_DISC;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_IDLE;  step <= 4'h0;  subch <= 5'h00;  dtype <= DEV_NONE;
      act <= 1'b0;  pf <= 1'b0;  pg_valid <= 1'b0;  pg_id <= 1'b0;
      for (int i = 0; i < NUM_WORKING; i++) begin
        w_ccw[i] <= 24'h0;  w_dadr[i] <= 24'h0;  w_cmd[i] <= 8'h0;
        w_cnt[i] <= 14'h0;  w_cd[i] <= 1'b0;  w_cc[i] <= 1'b0;
      end
      for (int i = 0; i < STORE_WORDS; i++) begin
        store[i] <= 32'h0;
      end
      bv <= 2'h0;  fill <= 1'b0;  drain <= 1'b0;  in_left <= 14'h0;
      steal_req <= 1'b0;  steal_we <= 1'b0;  steal_addr <= 24'h0;  steal_wdata <= 32'h0;
      end_valid <= 1'b0;  end_subch <= 5'h00;  end_code <= END_DONE;
    end else begin
      state <= next_state;  step <= next_step;  subch <= next_subch;  dtype <= next_dtype;
      act <= next_act;  pf <= next_pf;  pg_valid <= next_pg_valid;  pg_id <= next_pg_id;
      w_ccw <= next_w_ccw;  w_dadr <= next_w_dadr;  w_cmd <= next_w_cmd;
      w_cnt <= next_w_cnt;  w_cd <= next_w_cd;  w_cc <= next_w_cc;
      store <= next_store;
      bv <= next_bv;  fill <= next_fill;  drain <= next_drain;  in_left <= next_in_left;
      steal_req <= next_steal_req;  steal_we <= next_steal_we;
      steal_addr <= next_steal_addr;  steal_wdata <= next_steal_wdata;
      end_valid <= next_end_valid;  end_subch <= next_end_subch;  end_code <= next_end_code;
    end
  end

  // ****************************************************************
  // Microcode read port
  // ****************************************************************
  logic [31:0] next_ucode_data;

  // Registered so the sequencer sees a stable word
  always_comb begin
    next_ucode_data = store[ucode_addr];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ucode_data <= 32'h0;
    end else begin
      ucode_data <= next_ucode_data;
    end
  end

endmodule : dca_adapter

// *** src/dca_pkg.sv ***
package dca_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int NUM_STRINGS      = 4;
  localparam int SUBCH_PER_STRING = 8;
  localparam int NUM_SUBCH        = NUM_STRINGS * SUBCH_PER_STRING;
  localparam int NUM_WORKING      = 2;
  localparam int STORE_BYTES      = 512;
  localparam int STORE_WORDS      = STORE_BYTES / 4;
  localparam int PAGE_WORDS       = 16;

  localparam logic [6:0] PAGE_SLOT      = 7'h10;
  localparam logic [3:0] PAGE_LAST_STEP = 4'hf;
  localparam logic [3:0] MAX_FBA_A_DEVS = 4'h4;
  localparam logic [3:0] MAX_GROUP_DEVS = 4'h8;
  localparam logic [7:0] CKD_ADDR_MAX   = 8'h7f;

  // ****************************************************************
  // Processor storage layout
  // ****************************************************************
  localparam logic [23:0] SUBCH_AREA_BASE = 24'h010000;
  localparam logic [23:0] UCODE_AREA_BASE = 24'h020000;
  localparam logic [23:0] UCODE_PAGE_SIZE = 24'h000040;
  localparam logic [23:0] CCW_BYTES       = 24'h000008;

  // ****************************************************************
  // Command word fields
  // ****************************************************************
  localparam int         CCW_CHAIN_DATA_BIT = 31;
  localparam int         CCW_CHAIN_CMD_BIT  = 30;
  localparam logic [1:0] CMD_READ           = 2'h2;
  localparam logic [1:0] CMD_WRITE          = 2'h1;
  localparam logic [8:0] BLOCK_MASK         = 9'h1ff;

  // Reset configuration: first fixed-block type, 4 drives per string
  localparam logic [7:0] STD_BASE [NUM_STRINGS] = '{8'h40, 8'h50, 8'h60, 8'h70};
  localparam logic [3:0] STD_COUNT              = 4'h4;

  typedef enum logic [1:0] {DEV_NONE, DEV_FBA_A, DEV_FBA_B, DEV_CKD} dca_dev_t;
  typedef enum logic [1:0] {END_DONE, END_DISC, END_REJECT, END_ERROR} dca_end_t;
  typedef enum logic [2:0] {
    S_IDLE, S_LOAD, S_PAGE, S_FETCH, S_PREF, S_XFER, S_STAT, S_SAVE
  } dca_state_t;

endpackage : dca_pkg

// *** src/dca_string_decode.sv ***
`timescale 1ns/1ps
module dca_string_decode
  import dca_pkg::*;
#(
  parameter logic [1:0] STRING_ID = 2'h0
) (
  input  dca_dev_t   str_type,
  input  wire [7:0]  str_base,
  input  wire [3:0]  str_count,
  input  wire [7:0]  addr,
  output logic       hit,
  output logic [4:0] subch
);

  logic [7:0] offset;
  logic [3:0] limit;

  // Fixed-block type A strings hold four drives, the others a group of eight
  always_comb begin
    offset = addr - str_base;
    if (str_type == DEV_FBA_A) begin
      limit = (str_count > MAX_FBA_A_DEVS) ? MAX_FBA_A_DEVS : str_count;
    end else begin
      limit = (str_count > MAX_GROUP_DEVS) ? MAX_GROUP_DEVS : str_count;
    end
    hit = (str_type != DEV_NONE) && (offset < {4'h0, limit})
          && ((str_type != DEV_CKD) || (addr <= CKD_ADDR_MAX));
    subch = {STRING_ID, offset[2:0]};
  end

endmodule : dca_string_decode
